// [rtl/sac_pkg.sv]
package sac_pkg;

  // converter geometry
  localparam int unsigned MAG_BITS    = 12;
  localparam int unsigned RES_BITS    = 13;
  localparam int unsigned BYTE_BITS   = 8;
  localparam int unsigned BUS_BITS    = 13;
  localparam int unsigned STEP_DIV    = 8;
  localparam int unsigned DIV_BITS    = 3;
  localparam int unsigned CNT_BITS    = 4;
  localparam int unsigned HI_EXT_BITS = 4;

  // test counter: sign step first, then one count per magnitude bit
  localparam logic [3:0] SIGN_STEP = 4'hD;
  localparam logic [3:0] LAST_STEP = 4'h1;
  localparam logic [3:0] CNT_IDLE  = 4'h0;

  // conversion_flag_word bit positions
  localparam int unsigned FLAG_ACTIVE = 6;
  localparam int unsigned FLAG_PTR    = 2;
  localparam int unsigned FLAG_EOC    = 1;
  localparam int unsigned FLAG_READY  = 0;

  // reset values
  localparam logic [11:0] DAC_ZERO   = 12'h000;
  localparam logic [12:0] LATCH_ZERO = 13'h0000;
  localparam logic [12:0] BUS_ZERO   = 13'h0000;
  localparam logic        SIGN_POS   = 1'b0;
  localparam logic        PTR_HIGH   = 1'b0;

  // host strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic flag_sel_n;
  } sac_strobe_type;

  typedef struct packed {
    logic ready;
    logic eoc;
    logic ptr;
    logic active;
  } sac_flags_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CONV   = 2'b01,
    ST_UPDATE = 2'b11,
    ST_NOTIFY = 2'b10
  } sac_state_type;

endpackage

// [rtl/sac_timing_gen.sv]
`timescale 1ns/10ps
`default_nettype none

module sac_timing_gen (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  input  wire logic restart,
  // timing outputs
  output var  logic step_clk,
  output var  logic step
);

  logic [sac_pkg::DIV_BITS-1:0] div_q;
  logic [sac_pkg::DIV_BITS-1:0] div_d;
  logic                         wrap;

  assign wrap  = (div_q == sac_pkg::DIV_BITS'(sac_pkg::STEP_DIV - 1));
  assign div_d = (run && !restart) ? div_q + 1'b1 : '0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q    <= '0;
      step_clk <= 1'b0;
      step     <= 1'b0;
    end else begin
      div_q    <= div_d;
      step_clk <= div_q[sac_pkg::DIV_BITS-1];
      step     <= run && !restart && wrap;
    end
  end

endmodule

`default_nettype wire

// [rtl/sac_sar_core.sv]
`timescale 1ns/10ps
`default_nettype none

module sac_sar_core #(
  parameter int unsigned BITS = sac_pkg::MAG_BITS
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // sequencing
  input  wire logic            clr,
  input  wire logic            step,
  input  wire logic            cmp_in,
  // results
  output var  logic [BITS-1:0] trial,
  output var  logic            sign,
  output var  logic            done
);

  logic [sac_pkg::CNT_BITS-1:0] cnt_q;
  logic                         in_sign;
  logic                         in_bits;

  assign in_sign = step && (cnt_q == sac_pkg::SIGN_STEP);
  assign in_bits = step && (cnt_q != sac_pkg::SIGN_STEP) &&
                   (cnt_q != sac_pkg::CNT_IDLE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= sac_pkg::CNT_IDLE;
      sign  <= sac_pkg::SIGN_POS;
      done  <= 1'b0;
    end else begin
      done <= in_bits && (cnt_q == sac_pkg::LAST_STEP);
      if (clr) begin
        cnt_q <= sac_pkg::SIGN_STEP;
        sign  <= sac_pkg::SIGN_POS;
      end else if (in_sign || in_bits) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (in_sign) begin
        sign <= cmp_in;
      end
    end
  end

  for (genvar i = 0; i < BITS; i++) begin : g_bit
    logic try_here;
    logic test_here;
    assign try_here  = (in_sign && i == BITS - 1) ||
                       (in_bits && cnt_q == sac_pkg::CNT_BITS'(i + 2));
    assign test_here = in_bits && cnt_q == sac_pkg::CNT_BITS'(i + 1);
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        trial[i] <= 1'b0;
      end else if (clr) begin
        trial[i] <= 1'b0;
      end else if (try_here) begin
        trial[i] <= 1'b1;
      end else if (test_here) begin
        trial[i] <= cmp_in;
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/sac_control.sv]
`timescale 1ns/10ps
`default_nettype none

module sac_control #(
  parameter bit BYTE_MODE = 1'b0
) (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  // host strobes
  input  wire sac_pkg::sac_strobe_type         strobe,
  // data bus, three-state as output and enable
  output var  logic [sac_pkg::BUS_BITS-1:0]    db_out,
  output var  logic                            db_oe,
  // host signalling
  output var  logic                            conversion_done_irq_n,
  output var  logic                            end_flag,
  output var  logic                            wait_release,
  // analog front end
  input  wire logic                            cmp_in,
  output var  logic [sac_pkg::MAG_BITS-1:0]    dac_code,
  output var  logic                            swap_inputs,
  output var  logic                            sar_step_clock
);

  ////////////////////////////////////////////////////////////////////////
  // strobe edges

  logic cs_low;
  logic wr_low;
  logic rd_low;
  logic wr_n_q;
  logic rd_n_q;
  logic wr_fall;
  logic rd_fall;
  logic start_w;
  logic flag_write;
  logic data_read;
  logic flag_read;
  logic read_active;

  // strobes are live levels checked against last clock's sample; an edge acts at the first clock that sees it low
  assign cs_low      = !strobe.cs_n;
  assign wr_low      = !strobe.wr_n;
  assign rd_low      = !strobe.rd_n;
  assign wr_fall     = wr_n_q && wr_low && cs_low;
  assign rd_fall     = rd_n_q && rd_low && cs_low;
  assign start_w     = wr_fall && strobe.flag_sel_n;
  assign flag_write  = wr_fall && !strobe.flag_sel_n;
  assign data_read   = rd_fall && strobe.flag_sel_n;
  assign flag_read   = rd_fall && !strobe.flag_sel_n;
  assign read_active = cs_low && rd_low;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      wr_n_q <= strobe.wr_n;
      rd_n_q <= strobe.rd_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  sac_pkg::sac_state_type state_q;
  sac_pkg::sac_state_type state_d;
  logic                   conv_active;
  logic                   core_clr;
  logic                   step;
  logic                   core_done;
  logic                   step_clk;
  logic                   sign;
  logic [sac_pkg::MAG_BITS-1:0] trial;
  logic                   complete_ff_q;
  logic                   complete_ff_d;
  logic                   set_complete;

  assign conv_active = (state_q == sac_pkg::ST_CONV);
  assign core_clr    = start_w || flag_write ||
                       (state_q == sac_pkg::ST_UPDATE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      sac_pkg::ST_IDLE: begin
        state_d = sac_pkg::ST_IDLE;
      end
      sac_pkg::ST_CONV: begin
        if (complete_ff_q) begin
          state_d = sac_pkg::ST_UPDATE;
        end
      end
      sac_pkg::ST_UPDATE: begin
        state_d = sac_pkg::ST_NOTIFY;
      end
      sac_pkg::ST_NOTIFY: begin
        state_d = sac_pkg::ST_IDLE;
      end
      default: begin
        state_d = sac_pkg::ST_IDLE;
      end
    endcase
    if (start_w) begin
      state_d = sac_pkg::ST_CONV;
    end
    if (flag_write) begin
      state_d = sac_pkg::ST_IDLE;
    end
  end

  assign set_complete  = core_done && conv_active;
  assign complete_ff_d = core_clr ? 1'b0 :
                         set_complete ? 1'b1 : complete_ff_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= sac_pkg::ST_IDLE;
      complete_ff_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      complete_ff_q <= complete_ff_d;
    end
  end

  sac_timing_gen u_timing (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .run      (conv_active),
    .restart  (core_clr),
    .step_clk (step_clk),
    .step     (step)
  );

  sac_sar_core #(
    .BITS (sac_pkg::MAG_BITS)
  ) u_core (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clr    (core_clr),
    .step   (step),
    .cmp_in (cmp_in),
    .trial  (trial),
    .sign   (sign),
    .done   (core_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // output latch and flags

  logic [sac_pkg::RES_BITS-1:0] mag_ext;
  logic [sac_pkg::RES_BITS-1:0] result_w;
  logic [sac_pkg::RES_BITS-1:0] latch_q;
  logic                         host_clr;
  logic                         in_update;
  logic                         in_notify;
  logic                         do_update;
  logic                         do_notify;
  logic                         ptr_q;
  logic                         ptr_d;
  logic                         ptr_home;
  logic                         ptr_flip;
  logic                         eoc_d;
  logic                         ready_q;
  logic                         ready_d;
  logic                         ready_clr;
  logic                         irq_n_d;
  logic                         irq_release;

  assign mag_ext   = {1'b0, trial};
  // magnitude plus sign folded to two's complement
  assign result_w  = sign ? sac_pkg::RES_BITS'(~mag_ext + 1'b1) : mag_ext;
  // start or status write cancels a pending update or notify
  assign host_clr  = start_w || flag_write;
  assign in_update = (state_q == sac_pkg::ST_UPDATE);
  assign in_notify = (state_q == sac_pkg::ST_NOTIFY);
  assign do_update = in_update && !host_clr;
  assign do_notify = in_notify && !host_clr;

  assign ptr_home = flag_write || do_update;
  assign ptr_flip = data_read && BYTE_MODE;
  assign ptr_d    = ptr_home ? sac_pkg::PTR_HIGH :
                    ptr_flip ? !ptr_q : ptr_q;

  assign eoc_d = do_notify ? 1'b1 :
                 host_clr ? 1'b0 : end_flag;

  assign ready_clr = host_clr || data_read || flag_read;
  assign ready_d   = do_notify ? 1'b1 :
                     ready_clr ? 1'b0 : ready_q;

  // falls at end, rises on read
  assign irq_release = host_clr || rd_fall;
  assign irq_n_d     = do_notify ? 1'b0 :
                       irq_release ? 1'b1 : conversion_done_irq_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q               <= sac_pkg::LATCH_ZERO;
      ptr_q                 <= sac_pkg::PTR_HIGH;
      end_flag              <= 1'b0;
      ready_q               <= 1'b0;
      conversion_done_irq_n <= 1'b1;
    end else begin
      if (do_update) begin
        latch_q <= result_w;
      end
      ptr_q                 <= ptr_d;
      end_flag              <= eoc_d;
      ready_q               <= ready_d;
      conversion_done_irq_n <= irq_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  sac_pkg::sac_flags_type       flags;
  logic [sac_pkg::BYTE_BITS-1:0] flag_word;
  logic [sac_pkg::BYTE_BITS-1:0] hi_byte;
  logic [sac_pkg::BYTE_BITS-1:0] lo_byte;
  logic [sac_pkg::BYTE_BITS-1:0] sel_byte;
  logic [sac_pkg::BUS_BITS-1:0]  data_word;
  logic [sac_pkg::BUS_BITS-1:0]  byte_bus;
  logic [sac_pkg::BUS_BITS-1:0]  flag_bus;
  logic [sac_pkg::BUS_BITS-1:0]  bus_d;
  logic                          db_oe_d;
  logic                          wait_d;

  assign flags.active = conv_active;
  assign flags.ptr    = ptr_q;
  assign flags.eoc    = end_flag;
  assign flags.ready  = ready_q;

  // active on bit 6, eoc on bit 1
  always_comb begin
    flag_word                       = '0;
    flag_word[sac_pkg::FLAG_ACTIVE] = flags.active;
    flag_word[sac_pkg::FLAG_PTR]    = flags.ptr;
    flag_word[sac_pkg::FLAG_EOC]    = flags.eoc;
    flag_word[sac_pkg::FLAG_READY]  = flags.ready;
  end

  // sign extended high byte, then low
  assign hi_byte  = {{sac_pkg::HI_EXT_BITS{latch_q[sac_pkg::MAG_BITS]}},
                     latch_q[sac_pkg::MAG_BITS-1:sac_pkg::BYTE_BITS]};
  assign lo_byte  = latch_q[sac_pkg::BYTE_BITS-1:0];
  assign sel_byte = ptr_q ? lo_byte : hi_byte;

  // upper lines idle low in byte mode and for the flag word
  assign byte_bus  = {{(sac_pkg::BUS_BITS-sac_pkg::BYTE_BITS){1'b0}},
                      sel_byte};
  assign flag_bus  = {{(sac_pkg::BUS_BITS-sac_pkg::BYTE_BITS){1'b0}},
                      flag_word};

  assign data_word = BYTE_MODE ? byte_bus : latch_q;

  assign bus_d = !rd_fall ? db_out :
                 strobe.flag_sel_n ? data_word : flag_bus;

  // drive follows chip select and read strobe
  assign db_oe_d = read_active;
  assign wait_d  = !rd_fall;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      db_out       <= sac_pkg::BUS_ZERO;
      db_oe        <= 1'b0;
      wait_release <= 1'b1;
    end else begin
      db_out       <= bus_d;
      db_oe        <= db_oe_d;
      wait_release <= wait_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog front end

  logic [sac_pkg::MAG_BITS-1:0] dac_d;
  logic                         swap_d;

  assign dac_d  = core_clr ? sac_pkg::DAC_ZERO : trial;
  assign swap_d = core_clr ? sac_pkg::SIGN_POS : sign;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code       <= sac_pkg::DAC_ZERO;
      swap_inputs    <= sac_pkg::SIGN_POS;
      sar_step_clock <= 1'b0;
    end else begin
      dac_code       <= dac_d;
      swap_inputs    <= swap_d;
      sar_step_clock <= step_clk;
    end
  end

endmodule

`default_nettype wire

// [tb/sac_analog_model.sv]
`timescale 1ns/10ps
`default_nettype none

module sac_analog_model (
  // converter side
  input  wire logic        [11:0] dac_code,
  input  wire logic               swap_inputs,
  output var  logic               cmp_in,
  // stimulus, input sits half a code beyond vin, away from zero
  input  wire logic signed [12:0] vin
);
  logic signed [12:0] eff;

  assign eff = swap_inputs ? -vin : vin;
  assign cmp_in = (dac_code == 12'h000) ? vin[12]
                : (eff >= $signed({1'b0, dac_code}));
endmodule

`default_nettype wire

// [tb/sac_control_asserts.sv]
`timescale 1ns/10ps
`default_nettype none

module sac_control_asserts #(
  parameter bit BYTE_MODE = 1'b0
) (
  // clock and reset
  input wire logic                         mclk,
  input wire logic                         rst_n,
  // host side
  input wire sac_pkg::sac_strobe_type      strobe,
  input wire logic [sac_pkg::BUS_BITS-1:0] db_out,
  input wire logic                         db_oe,
  input wire logic                         conversion_done_irq_n,
  input wire logic                         end_flag,
  input wire logic                         wait_release,
  // analog side
  input wire logic                         cmp_in,
  input wire logic [sac_pkg::MAG_BITS-1:0] dac_code,
  input wire logic                         swap_inputs,
  input wire logic                         sar_step_clock
);
  logic       wr_q;
  logic       rd_q;
  logic [7:0] cnt_q;
  wire        wr_fall;
  wire        start;
  wire        swr;
  wire        rd_fall;

  assign wr_fall = !strobe.cs_n && !strobe.wr_n && wr_q;
  assign start   = wr_fall && strobe.flag_sel_n;
  assign swr     = wr_fall && !strobe.flag_sel_n;
  assign rd_fall = !strobe.cs_n && !strobe.rd_n && rd_q;

  // cycles since the last write fall
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b1;
      rd_q  <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      wr_q  <= strobe.wr_n;
      rd_q  <= strobe.rd_n;
      cnt_q <= wr_fall ? 8'h00 : (cnt_q == 8'hFF ? cnt_q : cnt_q + 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_wait_pulse;
    !wait_release ##1 wait_release;
  endsequence
  sequence s_cleared;
    conversion_done_irq_n && !end_flag;
  endsequence

  property p_start;
    start |=> s_cleared ##0 (dac_code == 12'h000 && !swap_inputs);
  endproperty
  property p_read;
    rd_fall |=> (conversion_done_irq_n && db_oe) ##0 s_wait_pulse;
  endproperty
  property p_oe_off;
    (strobe.rd_n || strobe.cs_n) |=> !db_oe;
  endproperty
  property p_irq_eoc;
    $fell(conversion_done_irq_n) |-> end_flag;
  endproperty
  property p_conv_time;
    $rose(end_flag) |-> cnt_q >= 8'h64 && cnt_q <= 8'h73;
  endproperty
  property p_step;
    disable iff (!rst_n || wr_fall)
    $rose(sar_step_clock) |=> sar_step_clock[*3] ##1 !sar_step_clock;
  endproperty
  property p_idle;
    end_flag |-> !sar_step_clock;
  endproperty
  property p_sign;
    $rose(swap_inputs) |-> $past(dac_code) == 12'h000 && $past(cmp_in);
  endproperty
  property p_swr;
    swr |=> s_cleared ##2 !sar_step_clock;
  endproperty
  property p_byte;
    (BYTE_MODE && db_oe) |-> db_out[12:8] == 5'h00;
  endproperty

  a_start: assert property (p_start)
    else $error("start left stale outputs");
  a_read: assert property (p_read)
    else $error("read fall handling wrong");
  a_oe_off: assert property (p_oe_off)
    else $error("bus driven without read");
  a_irq_eoc: assert property (p_irq_eoc)
    else $error("interrupt before end flag");
  a_conv_time: assert property (p_conv_time)
    else $error("conversion length off");
  a_step: assert property (p_step)
    else $error("step clock not eighth rate");
  a_idle: assert property (p_idle)
    else $error("step clock runs when idle");
  a_sign: assert property (p_sign)
    else $error("swap outside sign step");
  a_swr: assert property (p_swr)
    else $error("status write did not reset");
  a_byte: assert property (p_byte)
    else $error("byte bus upper bits set");
endmodule

bind sac_control sac_control_asserts #(.BYTE_MODE(BYTE_MODE)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .strobe(strobe), .db_out(db_out),
  .db_oe(db_oe), .conversion_done_irq_n(conversion_done_irq_n),
  .end_flag(end_flag), .wait_release(wait_release), .cmp_in(cmp_in),
  .dac_code(dac_code), .swap_inputs(swap_inputs),
  .sar_step_clock(sar_step_clock));

`default_nettype wire

// [tb/sac_control_test.sv]
`timescale 1ns/10ps
`default_nettype none

module sac_control_test;
  logic                    mclk;
  logic                    rst_n;
  sac_pkg::sac_strobe_type strobe;
  logic [12:0]             db_b;
  logic [12:0]             db_p;
  logic                    irq_n;
  logic                    wr_b;
  logic                    oe;
  logic                    eoc;
  logic                    cmp;
  logic [11:0]             dac;
  logic                    swp;
  logic signed [12:0]      vin;
  logic [12:0]             res;
  logic [12:0]             d;
  logic [12:0]             dp;
  logic [7:0]              e;
  logic [7:0]              exp_q[$];
  logic [12:0]             tbl[4] = '{13'h0000, 13'h0FFF, 13'h1001, 13'h1FFF};
  integer                  seed = 79;
  int                      n_fail = 0;
  int                      comparisons = 0;

  sac_control #(.BYTE_MODE(1'b1)) uut (
    .mclk(mclk), .rst_n(rst_n), .strobe(strobe), .db_out(db_b), .db_oe(oe),
    .conversion_done_irq_n(irq_n), .end_flag(eoc), .wait_release(wr_b),
    .cmp_in(cmp), .dac_code(dac), .swap_inputs(swp), .sar_step_clock());
  sac_control #(.BYTE_MODE(1'b0)) uut_par (
    .mclk(mclk), .rst_n(rst_n), .strobe(strobe), .db_out(db_p), .db_oe(),
    .conversion_done_irq_n(), .end_flag(), .wait_release(), .cmp_in(cmp),
    .dac_code(), .swap_inputs(), .sar_step_clock());
  sac_analog_model u_ana (
    .dac_code(dac), .swap_inputs(swp), .cmp_in(cmp), .vin(vin));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one strobe cycle, select settled first, held until ready
  task acc(input logic wr, input logic fs);
    int i;
    @(posedge mclk);
    #2;
    strobe.cs_n = 1'b0;
    strobe.flag_sel_n = fs;
    repeat (25) @(posedge mclk);
    #2;
    if (wr) strobe.wr_n = 1'b0;
    else strobe.rd_n = 1'b0;
    @(posedge mclk);
    #2;
    d = db_b;
    dp = db_p;
    chk({12'h000, irq_n}, 13'h0001);
    if (!wr) chk({12'h000, wr_b}, 13'h0000);
    if (!wr) chk({12'h000, oe}, 13'h0001);
    i = 0;
    while (!wr_b && i < 8) begin
      @(posedge mclk);
      #2;
      i++;
    end
    if (!wr_b) begin
      n_fail++;
      finish_test;
    end
    @(posedge mclk);
    #2;
    strobe = 4'hF;
  endtask

  task start;
    acc(1'b1, 1'b1);
    res = vin;
  endtask

  // conversion end: high byte queued first
  task wait_eoc;
    int i;
    i = 0;
    while (irq_n && i < 200) begin
      @(posedge mclk);
      #2;
      i++;
    end
    if (irq_n) begin
      n_fail++;
      finish_test;
    end
    chk({12'h000, eoc}, 13'h0001);
    exp_q.delete();
    exp_q.push_back({{4{res[12]}}, res[11:8]});
    exp_q.push_back(res[7:0]);
  endtask

  task conv_read;
    int k;
    acc(1'b0, 1'b0);
    chk(d, 13'h0003);
    for (k = 0; k < 3; k++) begin
      acc(1'b0, 1'b1);
      e = exp_q.pop_front();
      exp_q.push_back(e);
      chk(d, {5'h00, e});
      chk(dp, res);
    end
    acc(1'b0, 1'b0);
    chk(d, 13'h0006);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    strobe = 4'hF;
    vin = 13'h0000;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    @(posedge mclk);
    #2;
    for (k = 0; k < 8; k++) begin
      vin = (k < 4) ? tbl[k] : 13'($random(seed) % 4096);
      start;
      wait_eoc;
      conv_read;
    end
    // restart straight after an unread end, then mid-conversion
    vin = 13'h0800;
    start;
    wait_eoc;
    vin = 13'h1ABC;
    start;
    acc(1'b0, 1'b0);
    chk(d, 13'h0040);
    vin = 13'h0555;
    start;
    wait_eoc;
    conv_read;
    // status write resets pointer, flags and a running conversion
    acc(1'b1, 1'b0);
    acc(1'b0, 1'b0);
    chk(d, 13'h0000);
    start;
    acc(1'b1, 1'b0);
    repeat (150) @(posedge mclk);
    #2;
    chk({12'h000, irq_n}, 13'h0001);
    acc(1'b0, 1'b0);
    chk(d, 13'h0000);
    finish_test;
  end
endmodule

`default_nettype wire
